// *** bus_status_flags.sv ***
// Purpose: status flags of the two-wire bus interface, read by the processor
// Assumes: link events are one-cycle pulses on the link clock
// Notes: events cross by toggles, levels by three-stage sampling

`timescale 1ns/1ps

// Functional notes
// - reset clears every status bit to zero
// - status readable as a whole byte or as a single selected bit
// - bits 7..0: master, arb lost, ext code, match, transmit, ack, start, stop
// - master flag is one only during master communication
// - master flag sets when this device generates a start condition
// - master clears on stop, arb loss, release write, enable falling, reset
// - arbitration loss sets arb lost flag and clears master flag together
// - arb lost clears after status read, on enable falling, and reset
// - arb lost clears on bit-manipulation instruction aimed at other registers
// - ext code flag sets at eighth clock when address nibble is 0000 or 1111
// - ext code clears on start, stop, release write, enable falling, reset
module bus_status_flags
    import bus_status_pkg::*;
(
    // system clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // link clock domain
    input wire logic i_link_clk,
    input wire link_events_t i_link_events,
    input wire logic [3:0] i_link_addr_nibble,
    input wire link_levels_t i_link_levels,
    // control bits from the control register
    input wire logic i_comm_release,
    input wire logic i_interface_enable,
    // processor access
    input wire logic [15:0] i_cpu_addr,
    input wire logic i_cpu_rd,
    input wire logic i_cpu_wr,
    input wire logic i_cpu_bit_op,
    input wire logic [2:0] i_cpu_bit_sel,
    // read answer
    output logic [7:0] o_cpu_rdata,
    output logic o_cpu_rbit,
    output logic o_cpu_rvalid,
    // live status
    output bus_status_t o_bus_status
);

    // ==========================================================
    // link domain: event toggles
    logic [NUM_EVENTS-1:0] tog_q;
    logic [NUM_EVENTS-1:0] tog_d;
    logic ext_hit;

    // toggle per event, extension match checked at the eighth clock
    always_comb
    begin
        ext_hit = i_link_events.addr_clock8 &&
                  ((i_link_addr_nibble == EXT_NIBBLE_LOW) ||
                   (i_link_addr_nibble == EXT_NIBBLE_HIGH));
        tog_d = tog_q ^ {i_link_events.start_generated,
                         i_link_events.start_detected,
                         i_link_events.stop_detected,
                         i_link_events.arbitration_loss,
                         ext_hit};
    end

    // link toggle registers
    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
            tog_q <= '0;
        else
            tog_q <= tog_d;
    end

    // ==========================================================
    // crossing into the system domain
    logic [NUM_CROSS-1:0] cross_in;
    logic [NUM_CROSS-1:0] s1_q;
    logic [NUM_CROSS-1:0] s2_q;
    logic [NUM_CROSS-1:0] s3_q;
    logic [NUM_CROSS-1:0] stable_q;
    logic [NUM_CROSS-1:0] stable_d;

    assign cross_in = {i_link_levels, tog_q};

    // three stages, value taken once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CROSS; gi++)
        begin : g_sync
            always_comb
            begin
                stable_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : stable_q[gi];
            end

            always_ff @(posedge i_sys_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    stable_q[gi] <= 1'b0;
                end
                else
                begin
                    s1_q[gi] <= cross_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    stable_q[gi] <= stable_d[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // system domain events
    logic [NUM_EVENTS-1:0] ev;
    logic ev_start_gen;
    logic ev_start_det;
    logic ev_stop_det;
    logic ev_arb;
    logic ev_ext;
    link_levels_t lv;

    // a toggle change is one event
    always_comb
    begin
        ev = stable_d[NUM_EVENTS-1:0] ^ stable_q[NUM_EVENTS-1:0];
        ev_start_gen = ev[4];
        ev_start_det = ev[3];
        ev_stop_det = ev[2];
        ev_arb = ev[1];
        ev_ext = ev[0];
        lv = stable_q[NUM_CROSS-1:NUM_EVENTS];
    end

    // ==========================================================
    // status flags
    bus_status_t status_q;
    bus_status_t status_d;
    logic ena_q;
    logic ena_fall;
    logic addr_hit;
    logic rd_hit;
    logic bitop_other;

    // flag next values; hardware sets win over clears, except stop and arb loss win over a master set
    always_comb
    begin
        ena_fall = ena_q && !i_interface_enable;
        addr_hit = (i_cpu_addr == BUS_STATUS_ADDR);
        rd_hit = i_cpu_rd && addr_hit;
        bitop_other = i_cpu_bit_op && (i_cpu_rd || i_cpu_wr) && !addr_hit;
        status_d = status_q;

        // master flag
        if (ev_stop_det || ev_arb)
            status_d.master_active = 1'b0;
        else if (ev_start_gen)
            status_d.master_active = 1'b1;
        else if (i_comm_release || ena_fall)
            status_d.master_active = 1'b0;

        // arbitration lost flag
        if (ev_arb)
            status_d.arbitration_lost = 1'b1;
        else if (rd_hit || ena_fall)
            status_d.arbitration_lost = 1'b0;
        else if (bitop_other)
            status_d.arbitration_lost = 1'b0;

        // extension code flag
        if (ev_ext)
            status_d.extension_code_seen = 1'b1;
        else if (ev_start_det || ev_stop_det || i_comm_release || ena_fall)
            status_d.extension_code_seen = 1'b0;

        // levels kept by the link engine
        status_d.address_match = lv.address_match;
        status_d.transmit_mode = lv.transmit_mode;
        status_d.acknowledge_seen = lv.acknowledge_seen;
        status_d.start_seen = lv.start_seen;
        status_d.stop_seen = lv.stop_seen;
    end

    // flag registers
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            status_q <= BUS_STATUS_RESET;
            ena_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            ena_q <= i_interface_enable;
        end
    end

    // ==========================================================
    // read answer
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic rbit_q;
    logic rbit_d;
    logic rvalid_q;
    logic rvalid_d;

    // byte and bit read capture the value before the read clears anything
    always_comb
    begin
        rvalid_d = rd_hit;
        rdata_d = rd_hit ? status_q : 8'h00;
        rbit_d = rd_hit ? status_q[i_cpu_bit_sel] : 1'b0;
    end

    // answer registers
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rdata_q <= 8'h00;
            rbit_q <= 1'b0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rbit_q <= rbit_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign o_cpu_rdata = rdata_q;
    assign o_cpu_rbit = rbit_q;
    assign o_cpu_rvalid = rvalid_q;
    assign o_bus_status = status_q;

    // ==========================================================
    // checks
    sequence s_arb_then_flags;
        ev_arb ##1 (status_q.arbitration_lost && !status_q.master_active);
    endsequence

    sequence s_read_taken;
        rd_hit && !ev_arb;
    endsequence

    property p_arb_loss;
        @(posedge i_sys_clk) disable iff (i_rst)
        ev_arb |-> s_arb_then_flags;
    endproperty
    a_arb_loss: assert property (p_arb_loss) else $error("arb loss flags wrong");

    property p_read_clears;
        @(posedge i_sys_clk) disable iff (i_rst)
        s_read_taken |=> !status_q.arbitration_lost && o_cpu_rvalid &&
            (o_cpu_rdata == $past(status_q));
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read answer wrong");

    property p_bitop_other;
        @(posedge i_sys_clk) disable iff (i_rst)
        bitop_other && !ev_arb |=> !status_q.arbitration_lost;
    endproperty
    a_bitop_other: assert property (p_bitop_other) else $error("bit op no clear");

    property p_master_set;
        @(posedge i_sys_clk) disable iff (i_rst)
        ev_start_gen && !ev_stop_det && !ev_arb |=> status_q.master_active;
    endproperty
    a_master_set: assert property (p_master_set) else $error("master not set");

    property p_master_clear;
        @(posedge i_sys_clk) disable iff (i_rst)
        (i_comm_release || ena_fall || ev_stop_det) && !ev_start_gen
            |=> !status_q.master_active;
    endproperty
    a_master_clear: assert property (p_master_clear) else $error("master not cleared");

    property p_ext_set;
        @(posedge i_sys_clk) disable iff (i_rst)
        ev_ext |=> status_q.extension_code_seen;
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("ext code not set");

    property p_ext_clear;
        @(posedge i_sys_clk) disable iff (i_rst)
        (ev_start_det || ev_stop_det || i_comm_release || ena_fall) && !ev_ext
            |=> !status_q.extension_code_seen;
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("ext code not cleared");

    property p_write_inert;
        @(posedge i_sys_clk) disable iff (i_rst)
        i_cpu_wr && addr_hit && !i_cpu_rd && (ev == '0) && !i_comm_release && !ena_fall
            && (stable_d == stable_q) && (lv == status_q[4:0]) |=> $stable(status_q);
    endproperty
    a_write_inert: assert property (p_write_inert) else $error("write changed flags");

    property p_bit_read;
        @(posedge i_sys_clk) disable iff (i_rst)
        rd_hit |=> o_cpu_rbit == $past(status_q[i_cpu_bit_sel]);
    endproperty
    a_bit_read: assert property (p_bit_read) else $error("bit read wrong");

    property p_event_latency;
        @(posedge i_sys_clk) disable iff (i_rst)
        $changed(tog_q[1]) |-> ##[1:6] ev_arb;
    endproperty
    a_event_latency: assert property (p_event_latency) else $error("arb event lost");

    property p_after_reset;
        @(posedge i_sys_clk)
        $fell(i_rst) |-> (status_q == BUS_STATUS_RESET);
    endproperty
    a_after_reset: assert property (p_after_reset) else $error("reset value wrong");

endmodule

// *** bus_status_pkg.sv ***
// Purpose: shared constants and carrier types for the bus status flag block
// Assumes: byte-wide processor access, one status register at a fixed address
// Notes: field order of the status struct is the register's bit order, msb first

package bus_status_pkg;

    // ==========================================================
    // register map
    localparam logic [15:0] BUS_STATUS_ADDR = 16'hFFA5;
    localparam logic [7:0] BUS_STATUS_RESET = 8'h00;

    // ==========================================================
    // field positions
    localparam int BIT_MASTER_ACTIVE = 7;
    localparam int BIT_ARBITRATION_LOST = 6;
    localparam int BIT_EXTENSION_CODE_SEEN = 5;
    localparam int BIT_ADDRESS_MATCH = 4;
    localparam int BIT_TRANSMIT_MODE = 3;
    localparam int BIT_ACKNOWLEDGE_SEEN = 2;
    localparam int BIT_START_SEEN = 1;
    localparam int BIT_STOP_SEEN = 0;

    // ==========================================================
    // extension code address nibbles
    localparam logic [3:0] EXT_NIBBLE_LOW = 4'h0;
    localparam logic [3:0] EXT_NIBBLE_HIGH = 4'hF;

    // ==========================================================
    // crossing widths
    localparam int NUM_EVENTS = 5;
    localparam int NUM_LEVELS = 5;
    localparam int NUM_CROSS = NUM_EVENTS + NUM_LEVELS;

    // ==========================================================
    // status register layout, bit 7 down to bit 0
    typedef struct packed {
        logic master_active;
        logic arbitration_lost;
        logic extension_code_seen;
        logic address_match;
        logic transmit_mode;
        logic acknowledge_seen;
        logic start_seen;
        logic stop_seen;
    } bus_status_t;

    // one-cycle bus events on the link clock
    typedef struct packed {
        logic start_generated;
        logic start_detected;
        logic stop_detected;
        logic arbitration_loss;
        logic addr_clock8;
    } link_events_t;

    // status levels kept by the link engine
    typedef struct packed {
        logic address_match;
        logic transmit_mode;
        logic acknowledge_seen;
        logic start_seen;
        logic stop_seen;
    } link_levels_t;

endpackage

// *** link_partner.sv ***
// Purpose: far-side link engine model driving bus events and levels
// Assumes: events are one link-cycle pulses driven on the falling link edge
// Notes: link clock runs only inside short frames
`timescale 1ns/1ps
module link_partner
    import bus_status_pkg::*;
(
    // free-running source clock
    input wire logic i_free_clk,
    // link side
    output logic o_link_clk,
    output link_events_t o_events,
    output logic [3:0] o_nibble,
    output link_levels_t o_levels
);
    // ==========================================================
    // frame gating
    logic frame_q = 1'b0;
    // gate only changes while the source is low, so no glitch
    assign o_link_clk = i_free_clk & frame_q;
    initial
    begin
        o_events = '0;
        o_nibble = 4'h0;
        o_levels = '0;
    end
    // ==========================================================
    // one event inside a frame
    task automatic send(input link_events_t ev, input logic [3:0] nib);
        @(negedge i_free_clk) frame_q = 1'b1;
        @(negedge i_free_clk);
        o_events = ev;
        o_nibble = nib;
        @(negedge i_free_clk);
        o_events = '0;
        o_nibble = ~nib; // released nibble does not keep its value
        repeat (2) @(negedge i_free_clk);
        frame_q = 1'b0;
    endtask
    // status levels of the engine
    task automatic set_levels(input link_levels_t lv);
        o_levels = lv;
    endtask
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench for the bus status flag block
// Assumes: partner model supplies link clock, events and levels
// Notes: read answers are checked from a queue of expected values
`timescale 1ns/1ps
module testbench
    import bus_status_pkg::*;
;
    logic sys_clk = 0, free_clk = 0, rst = 1, rel = 0, ena = 0;
    logic rd = 0, wr = 0, bop = 0;
    logic [15:0] addr = 16'h0000;
    logic [2:0] bsel = 3'h0;
    logic link_clk, rbit, rvalid;
    logic [7:0] rdata;
    logic [3:0] nib, code;
    logic [8:0] expq[$];
    logic [8:0] e;
    link_events_t lev;
    link_levels_t llv;
    bus_status_t stat, want = '0;
    int n_errors = 0, cmp_count = 0, cycles = 0, i, seed = 32'h44CA;
    // ==========================================================
    // clocks and instances
    always #5 sys_clk = ~sys_clk;
    initial #2 forever #15 free_clk = ~free_clk;
    link_partner link_partner_inst (.i_free_clk(free_clk), .o_link_clk(link_clk),
        .o_events(lev), .o_nibble(nib), .o_levels(llv));
    bus_status_flags bus_status_flags_inst (.i_sys_clk(sys_clk), .i_rst(rst),
        .i_link_clk(link_clk), .i_link_events(lev), .i_link_addr_nibble(nib),
        .i_link_levels(llv), .i_comm_release(rel), .i_interface_enable(ena),
        .i_cpu_addr(addr), .i_cpu_rd(rd), .i_cpu_wr(wr), .i_cpu_bit_op(bop),
        .i_cpu_bit_sel(bsel), .o_cpu_rdata(rdata), .o_cpu_rbit(rbit),
        .o_cpu_rvalid(rvalid), .o_bus_status(stat));
    // ==========================================================
    // compare and report
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t byte got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic complete_run();
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // stimulus tasks
    task automatic access(input logic r, w, b, input logic [15:0] a, input logic [2:0] s);
        @(negedge sys_clk);
        {rd, wr, bop, addr, bsel} = {r, w, b, a, s};
        if (r && a == BUS_STATUS_ADDR)
            expq.push_back({want, want[s]});
        @(negedge sys_clk);
        {rd, wr, bop} = 3'h0;
        if ((r && a == BUS_STATUS_ADDR) || (b && (r || w) && a != BUS_STATUS_ADDR))
            want.arbitration_lost = 1'b0; // read or foreign bit-op clears
    endtask
    task automatic ev(input link_events_t x, input logic [3:0] n);
        link_partner_inst.send(x, n);
        repeat (8) @(negedge sys_clk);
    endtask
    function automatic logic [15:0] other();
        return 16'hFE00 | 16'($random(seed) & 8'hFF);
    endfunction
    // read answer watcher
    always @(negedge sys_clk)
    begin
        if (rvalid === 1'b1)
        begin
            if (expq.size() == 0)
            begin
                n_errors++;
                $display("MISMATCH %0t unexpected read answer", $time);
            end
            else
            begin
                e = expq.pop_front();
                chk8(rdata, e[8:1]);
                chk1(rbit, e[0]);
            end
        end
    end
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            complete_run();
        end
    end
    // ==========================================================
    // main sequence
    initial
    begin
        repeat (16) @(negedge sys_clk);
        rst = 0;
        ena = 1;
        chk8(stat, 8'h00);
        access(1, 0, 0, BUS_STATUS_ADDR, 3'h0);
        want[4:0] = 5'($random(seed));
        link_partner_inst.set_levels(want[4:0]);
        ev(5'h10, 4'h0);
        want.master_active = 1'b1;
        chk8(stat, want);
        for (i = 0; i < 3; i++)
        begin
            code = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
            ev(5'h01, code);
            want.extension_code_seen = (code == 4'h0 || code == 4'hF);
            chk8(stat, want);
            ev(5'h08, 4'h5);
            want.extension_code_seen = 1'b0;
            chk8(stat, want);
        end
        ev(5'h01, 4'hF);
        ev(5'h04, 4'h3);
        want[7:5] = 3'h0;
        chk8(stat, want);
        ev(5'h10, 4'h0);
        ev(5'h02, 4'h0);
        want[7:6] = 2'h1;
        chk8(stat, want);
        access(0, 1, 0, BUS_STATUS_ADDR, 3'h0);
        chk8(stat, want);
        for (i = 0; i < 8; i++)
            access(1, 0, 1, BUS_STATUS_ADDR, 3'(i));
        chk8(stat, want);
        ev(5'h02, 4'h0);
        want.arbitration_lost = 1'b1;
        access(1, 0, 0, other(), 3'h0);
        chk8(stat, want);
        access(0, 1, 1, other(), 3'h0);
        chk8(stat, want);
        ev(5'h10, 4'h0);
        ev(5'h01, 4'h0);
        chk8(stat, want | 8'hA0);
        @(negedge sys_clk) rel = 1;
        @(negedge sys_clk) rel = 0;
        repeat (2) @(negedge sys_clk);
        chk8(stat, want);
        ev(5'h02, 4'h0);
        ev(5'h10, 4'h0);
        ev(5'h01, 4'hF);
        want[7:5] = 3'h7;
        chk8(stat, want);
        @(negedge sys_clk) ena = 0;
        repeat (3) @(negedge sys_clk);
        want[7:5] = 3'h0;
        chk8(stat, want);
        ena = 1;
        want[4:0] = 5'($random(seed));
        link_partner_inst.set_levels(want[4:0]);
        repeat (8) @(negedge sys_clk);
        access(1, 0, 0, BUS_STATUS_ADDR, 3'h4);
        chk8(stat, want);
        repeat (3) @(negedge sys_clk);
        // mid-run reset, then levels return through the crossing
        ev(5'h10, 4'h0);
        rst = 1;
        repeat (2) @(negedge sys_clk);
        chk8(stat, 8'h00);
        rst = 0;
        @(negedge sys_clk);
        chk8(stat, 8'h00);
        repeat (8) @(negedge sys_clk);
        chk8(stat, {3'h0, want[4:0]});
        if (expq.size() != 0)
        begin
            n_errors++;
            $display("MISMATCH %0t read answer missing", $time);
        end
        complete_run();
    end
endmodule
